/* File: verilog/ccsum_pkg.sv */
// Constants for the image checksum block and its two-entry input buffer.
// Assumes a single clock; the buffer sits between the reader and the adder.
package ccsum_pkg;

  // ==========================================================
  // Stream layout
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int ITEM_W = 1 + 2 + ADDR_W + DATA_W;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    SPACE_PROG = 2'h0,
    SPACE_CFG = 2'h1,
    SPACE_ID = 2'h2,
    SPACE_EE = 2'h3
  } ccsum_space_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_DONE = 2'h3
  } ccsum_state_t;

  // ==========================================================
  // Configuration area
  localparam logic [ADDR_W-1:0] CFG_BASE = 24'h300000;
  localparam logic [3:0] CFG_LAST_OFS = 4'hD;
  localparam int NUM_CFG = 14;
  localparam logic [3:0] CFG_PROT_LO_OFS = 4'h8;
  localparam logic [3:0] CFG_PROT_HI_OFS = 4'h9;
  localparam int BOOT_PROT_BIT = 6;
  localparam logic [DATA_W-1:0] SUM_RESET = 16'h0000;

  // ==========================================================
  // Per-variant tables, byte 0 of the config area in the low bits
  localparam int NUM_VARIANTS = 4;
  typedef logic [NUM_CFG*8-1:0] ccsum_masks_t;
  localparam ccsum_masks_t CFG_MASKS [NUM_VARIANTS] = '{
    112'h40_0F_E0_0F_C0_0F_00_C5_87_00_1F_1F_CF_00,
    112'h40_0F_E0_0F_C0_0F_00_C5_86_00_1F_1F_CF_00,
    112'h40_3F_E0_3F_C0_3F_00_C5_86_00_1F_1F_CF_00,
    112'h40_3F_E0_3F_C0_3F_00_C5_86_00_1F_1F_CF_00
  };
  // Last program byte address of each variant
  localparam logic [ADDR_W-1:0] LAST_PROG [NUM_VARIANTS] = '{
    24'h00FFFF, 24'h00FFFF, 24'h013FFF, 24'h017FFF
  };

endpackage

/* File: verilog/ccsum_buf.sv */
// Two-entry FIFO with valid/ready on both sides.
// Assumes the same clock and reset as its user; ce low freezes it.
`timescale 1ns/1ns
module ccsum_buf import ccsum_pkg::*; #(
  parameter int WIDTH = ITEM_W,
  parameter int DEPTH = BUF_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  // Fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // Drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  assign wr_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign rd_valid = (cnt_reg != '0);
  assign rd_data = mem_reg[rp_reg];
  assign push = wr_valid & wr_ready;
  assign pop = rd_valid & rd_ready;

  always_ff @(posedge clock) begin
    if (ce && push) begin
      mem_reg[wp_reg] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wp_reg <= (wp_reg == PW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == PW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

/* File: verilog/ccsum_top.sv */
// Checksum of a nonvolatile image: program words, masked config bytes,
// and ID words when any block is code-protected.
// Assumes a reader on the same clock streams tagged words, last one flagged.
`timescale 1ns/1ns

module ccsum_top import ccsum_pkg::*; #(
  parameter int VARIANT = 0
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  // Control
  input wire logic start,
  // Word stream from the reader
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_space,
  input wire logic [ADDR_W-1:0] in_addr,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic in_last,
  // Result
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] checksum
);

  // ==========================================================
  // Input buffer
  logic b_valid;
  logic b_ready;
  logic [ITEM_W-1:0] b_item;

  ccsum_buf u_buf (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data({in_last, in_space, in_addr, in_data}),
    .rd_valid(b_valid),
    .rd_ready(b_ready),
    .rd_data(b_item)
  );

  logic it_last;
  ccsum_space_t it_space;
  logic [ADDR_W-1:0] it_addr;
  logic [DATA_W-1:0] it_data;

  assign it_last = b_item[ITEM_W-1];
  assign it_space = ccsum_space_t'(b_item[ITEM_W-2 -: 2]);
  assign it_addr = b_item[DATA_W +: ADDR_W];
  assign it_data = b_item[DATA_W-1:0];

  // ==========================================================
  // Control
  ccsum_state_t state_reg;
  ccsum_state_t state_next;
  logic fire;

  assign b_ready = (state_reg == ST_RUN);
  assign fire = b_valid & b_ready;
  assign busy = (state_reg == ST_RUN);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fire && it_last) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (start) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Term selection
  localparam ccsum_masks_t MASKS = CFG_MASKS[VARIANT];
  localparam logic [ADDR_W-1:0] LAST_ADDR = LAST_PROG[VARIANT];

  logic [ADDR_W-1:0] cfg_ofs_full;
  logic [3:0] cfg_ofs;
  logic cfg_hit;
  logic [7:0] cfg_mask;
  logic [7:0] cfg_byte;
  logic [DATA_W-1:0] main_term;

  assign cfg_ofs_full = it_addr - CFG_BASE;
  assign cfg_ofs = cfg_ofs_full[3:0];
  assign cfg_hit = (it_space == SPACE_CFG) && (it_addr >= CFG_BASE)
                   && (cfg_ofs_full <= ADDR_W'(CFG_LAST_OFS));
  // Per-offset mask table; only offsets inside the area select a mask
  logic [7:0] mask_tab [NUM_CFG];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_mask
      assign mask_tab[gi] = MASKS[gi*8 +: 8];
    end
  endgenerate

  always_comb begin
    cfg_mask = 8'h00;
    if (cfg_hit) begin
      cfg_mask = mask_tab[cfg_ofs];
    end
  end
  assign cfg_byte = it_data[7:0] & cfg_mask;

  always_comb begin
    main_term = '0;
    if (it_space == SPACE_PROG && it_addr <= LAST_ADDR) begin
      main_term = it_data;
    end else if (cfg_hit) begin
      main_term = {8'h00, cfg_byte};
    end
    // Data EEPROM and stray words contribute nothing
  end

  // ==========================================================
  // Code-protect detection, cleared bits mean protected
  logic prot_reg;
  logic prot_next;

  always_comb begin
    prot_next = prot_reg;
    if (fire && cfg_hit && cfg_ofs == CFG_PROT_LO_OFS
        && cfg_byte != cfg_mask) begin
      prot_next = 1'b1;
    end
    if (fire && cfg_hit && cfg_ofs == CFG_PROT_HI_OFS
        && cfg_mask[BOOT_PROT_BIT] && !cfg_byte[BOOT_PROT_BIT]) begin
      prot_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prot_reg <= 1'b0;
    end else if (ce) begin
      prot_reg <= (start && state_reg != ST_RUN) ? 1'b0 : prot_next;
    end
  end

  // ==========================================================
  // Accumulators, sixteen bits with carries dropped
  logic [DATA_W-1:0] sum_reg;
  logic [DATA_W-1:0] sum_next;
  logic [DATA_W-1:0] id_sum_reg;
  logic [DATA_W-1:0] id_sum_next;

  assign sum_next = fire ? sum_reg + main_term : sum_reg;
  assign id_sum_next = (fire && it_space == SPACE_ID) ? id_sum_reg + it_data
                       : id_sum_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      sum_reg <= SUM_RESET;
      id_sum_reg <= SUM_RESET;
    end else if (ce) begin
      if (start && state_reg != ST_RUN) begin
        sum_reg <= SUM_RESET;
        id_sum_reg <= SUM_RESET;
      end else begin
        sum_reg <= sum_next;
        id_sum_reg <= id_sum_next;
      end
    end
  end

  // ==========================================================
  // Result
  logic [DATA_W-1:0] checksum_reg;
  logic done_reg;

  assign checksum = checksum_reg;
  assign done = done_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      checksum_reg <= SUM_RESET;
      done_reg <= 1'b0;
    end else if (ce) begin
      if (start && state_reg != ST_RUN) begin
        done_reg <= 1'b0;
      end else if (fire && it_last) begin
        checksum_reg <= sum_next + (prot_next ? id_sum_next : SUM_RESET);
        done_reg <= 1'b1;
      end
    end
  end

endmodule

/* File: test/ccsum_chk.sv */
// Port checker for the image checksum block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module ccsum_chk import ccsum_pkg::*; (
  // Clock and control
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic start,
  // Stream and result
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic in_last,
  input wire logic busy,
  input wire logic done,
  input wire logic [DATA_W-1:0] checksum
);
  // ==========================================
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  chk_reset_vals: assert property ($past(srst) |->
    in_ready && !busy && !done && checksum == SUM_RESET) else $error("bad reset values");
  chk_busy_done_excl: assert property (!(busy && done)) else $error("busy with done");
  chk_start_runs: assert property (ce && start && !busy |=> busy) else $error("start lost");
  chk_start_clears: assert property (ce && start && done |=> !done) else $error("done kept");
  chk_done_holds: assert property (done && !start |=> done && $stable(checksum))
    else $error("result moved");
  chk_done_cause: assert property ($rose(done) |-> $past(busy)) else $error("done w/o run");
  chk_busy_to_done: assert property ($fell(busy) && !$past(srst) |-> done)
    else $error("run ended w/o done");
  chk_freeze_state: assert property (!ce |=> $stable(checksum) && $stable(done) && $stable(busy))
    else $error("moved while frozen");
  chk_last_done: assert property (ce && in_valid && in_ready && in_last && busy |=>
    !done ##[1:60] done) else $error("no done after last");
endmodule
bind ccsum_top ccsum_chk u_chk (.clock(clock), .srst(srst), .ce(ce), .start(start),
  .in_valid(in_valid), .in_ready(in_ready), .in_last(in_last), .busy(busy), .done(done),
  .checksum(checksum));

/* File: test/ccsum_reader.sv */
// Reader model offering tagged image words to the checksum block.
// Assumes it changes lines at the falling edge; a word goes at a rising edge.
`timescale 1ns/1ns
module ccsum_reader import ccsum_pkg::*; (
  // Clock and handshake
  input wire logic clock,
  input wire logic ce,
  input wire logic in_ready,
  output logic in_valid,
  // Word
  output logic [1:0] in_space,
  output logic [ADDR_W-1:0] in_addr,
  output logic [DATA_W-1:0] in_data,
  output logic in_last
);
  logic stuck = 1'b0;
  initial begin
    in_valid = 1'b0;
    in_space = 2'h3;
    in_addr = 24'h000000;
    in_data = 16'h0000;
    in_last = 1'b0;
  end
  // Offer a word, held until taken
  task automatic send(input logic [1:0] s, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic l, input int gap);
    int n;
    @(negedge clock);
    if (gap > 0) begin
      in_valid = 1'b0;
      in_data = ~in_data;
      repeat (gap) @(negedge clock);
    end
    in_valid = 1'b1;
    in_space = s;
    in_addr = a;
    in_data = d;
    in_last = l;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!(in_ready && ce) && n < 200);
    if (n == 200) stuck = 1'b1;
  endtask
  task automatic idle();
    @(negedge clock);
    in_valid = 1'b0;
    in_data = ~in_data;
    in_addr = ~in_addr;
  endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the image checksum block.
// Assumes the reader model beside it and the checker bound to the top.
`timescale 1ns/1ns
module testbench import ccsum_pkg::*;;
  localparam int V = 2;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic in_valid, in_ready, in_last, busy, done, prot;
  logic [1:0] in_space;
  logic [ADDR_W-1:0] in_addr;
  logic [DATA_W-1:0] in_data, checksum, exp_sum, id_sum;
  int errors = 0;
  int total_checks = 0;
  always #10 clock = ~clock;
  always @(negedge clock) ce <= srst || ($urandom % 6 != 0);
  ccsum_top #(.VARIANT(V)) dut (.clock(clock), .srst(srst), .ce(ce), .start(start),
    .in_valid(in_valid), .in_ready(in_ready), .in_space(in_space), .in_addr(in_addr),
    .in_data(in_data), .in_last(in_last), .busy(busy), .done(done), .checksum(checksum));
  ccsum_reader rdr (.clock(clock), .ce(ce), .in_ready(in_ready), .in_valid(in_valid),
    .in_space(in_space), .in_addr(in_addr), .in_data(in_data), .in_last(in_last));
  // ==========================================
  // Expectation and checking
  function automatic logic [DATA_W-1:0] cfg_part(input logic [3:0] o, input logic [7:0] d);
    return {8'h00, d & CFG_MASKS[V][o*8 +: 8]};
  endfunction
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic item(input logic [1:0] s, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic l);
    case (s)
      SPACE_PROG: if (a <= LAST_PROG[V]) exp_sum += d;
      SPACE_CFG: if (a >= CFG_BASE && a <= CFG_BASE + 24'hD) begin
        exp_sum += cfg_part(a[3:0], d[7:0]);
        if (a[3:0] == 4'h8) prot |= cfg_part(4'h8, d[7:0]) != cfg_part(4'h8, 8'hFF);
        if (a[3:0] == 4'h9) prot |= !d[6];
      end
      SPACE_ID: id_sum += d;
      default: ;
    endcase
    rdr.send(s, a, d, l, $urandom % 3);
  endtask
  // ==========================================
  // One image pass
  task automatic run(input int r);
    int n;
    int w;
    logic [DATA_W-1:0] d;
    exp_sum = SUM_RESET;
    id_sum = SUM_RESET;
    prot = 1'b0;
    fork
      begin
        repeat (r * 3) @(negedge clock);
        start = 1'b1;
        for (w = 0; w < 50 && busy !== 1'b1; w++) @(negedge clock);
        start = 1'b0;
      end
      begin
        item(SPACE_PROG, 24'h000000, 16'hFFFF, 1'b0);
        item(SPACE_PROG, LAST_PROG[V] - 24'h1, 16'($urandom), 1'b0);
        item(SPACE_PROG, LAST_PROG[V] + 24'h1, 16'($urandom), 1'b0);
        item(SPACE_EE, 24'hF00000, 16'($urandom), 1'b0);
        for (n = 0; n < 20; n++) item(SPACE_PROG, 24'($urandom) & 24'h01FFFE, 16'($urandom), 1'b0);
        for (n = 0; n < 15; n++) begin
          d = (r == 0) ? 16'hFFFF : 16'($urandom);
          if (r >= 2 && n == 8) d = 16'hFFFF;
          if (r >= 2 && n == 9) d = (r == 2) ? 16'hFFBF : 16'hFF7F;
          item(SPACE_CFG, CFG_BASE + 24'(n), d, 1'b0);
        end
        for (n = 0; n < 4; n++) item(SPACE_ID, 24'h200000 + 24'(2 * n), 16'($urandom), 1'b0);
        item(SPACE_EE, 24'hF00002, 16'h1234, 1'b1);
      end
    join
    rdr.idle();
    for (n = 0; n < 100 && done !== 1'b1; n++) @(negedge clock);
    check({15'h0000, done}, 16'h0001);
    check(checksum, exp_sum + (prot ? id_sum : SUM_RESET));
    if (rdr.stuck || w == 50) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(86));
    repeat (4) @(negedge clock);
    srst = 1'b0;
    check(checksum, SUM_RESET);
    for (int r = 0; r < 4; r++) run(r);
    // Reset with a result standing, then a run whose first words wait in the buffer
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    check({14'h0000, busy, done}, 16'h0000);
    check(checksum, SUM_RESET);
    run(1);
    complete_run();
  end
endmodule
